/* acs_defines.svh */
// register indices, field positions, reset values and timing figures of the channel sequencer
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH

// ==================================================
// register indices (byte address is four times the index)
`define ACS_IDX_CFG 6'h02
`define ACS_IDX_CHAN 6'h03
`define ACS_IDX_RANGE0 6'h04
`define ACS_IDX_RANGE3 6'h07
`define ACS_IDX_FRAME 6'h10
`define ACS_IDX_STATUS 6'h11
`define ACS_IDX_STACK0 6'h20
`define ACS_IDX_STACK31 6'h3F

// ==================================================
// field positions
`define ACS_CFG_BURST 6
`define ACS_CFG_SEQ 5
`define ACS_STK_LAST 8
`define ACS_SEL_B_MSB 7
`define ACS_SEL_B_LSB 4
`define ACS_SEL_A_MSB 3
`define ACS_SEL_A_LSB 0
`define ACS_FR_WRITE 15
`define ACS_FR_ADDR_MSB 14
`define ACS_FR_ADDR_LSB 9
`define ACS_FR_DATA_MSB 8
`define ACS_FR_DATA_LSB 0

// ==================================================
// reset values and sizes
`define ACS_CFG_RST 9'h000
`define ACS_CHAN_RST 9'h000
`define ACS_RANGE_RST 9'h0FF
`define ACS_STACK_RST 9'h000
`define ACS_HW_PAIRS 8
`define ACS_STACK_DEPTH 32
`define ACS_SYNC_WAIT 2'h2
`define ACS_RESP_OKAY 2'h0
`define ACS_RESP_SLVERR 2'h2

// ==================================================
// timing
`define ACS_CLK_NS 10
`define ACS_FIRST_EXTRA_NS 25

`endif

/* acs_pkg.sv */
// types of the channel sequencer
package acs_pkg;

   // ==================================================
   // sequencer states
   typedef enum logic [0:0] {
      ACS_IDLE,
      ACS_CONV
   } acs_state_e;

   // ==================================================
   // complete state of the sequencer
   typedef struct packed {
      logic cv_s1;
      logic cv_s2;
      logic cv_prev;
      logic part_s1;
      logic part_s2;
      logic mode_s1;
      logic mode_s2;
      logic seq_s1;
      logic seq_s2;
      logic burst_s1;
      logic burst_s2;
      logic [2:0] cnt_s1;
      logic [2:0] cnt_s2;
      logic [1:0] strap_cnt;
      logic strap_done;
      logic hw_mode;
      logic hw_seq;
      logic hw_burst;
      logic [2:0] hw_last;
      logic [8:0] cfg;
      logic [8:0] chan;
      logic [3:0][8:0] range;
      logic [31:0][8:0] stack;
      acs_state_e st;
      logic [15:0] tmr;
      logic [4:0] ptr;
      logic busy;
      logic conv_stb;
      logic [3:0] a_sel;
      logic [3:0] b_sel;
      logic [4:0] step;
      logic [5:0] seq_len;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [15:0] frame_rd;
   } acs_state_s;

endpackage

/* acs_sequencer.sv */
// channel sequencer with axi4-lite register slave
//
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "acs_defines.svh"

// ==================================================
// Overview of operation
// - frame: bit 15 write flag, bits 14:9 address, bits 8:0 data
// - hardware mode starts at pair zero and ascends to the last pair
// - software mode runs 32 freely programmed A/B or diagnostic steps
// - burst converts the whole sequence per start; otherwise one step per start
// - hardware sequencer enable pin is caught at reset release, fixed until reset
// - channel-count pins at release set last pair; value n means pairs 0..n
// - pins held through the last busy pulse set the next sequence length
// - software depth 1..32, ended by the step with its last flag, then wraps
// - each step converts the A and B channels named in its select fields
// - software sequencer runs only while the config enable bit is one
// - after the final step, the next start begins again at step zero
// - partial reset returns the pointer to step zero, registers untouched
// - burst starts on the rising start edge; busy stays high until all done
// - burst results come out in step order; reads equal sequence length
// - burst lasts one conversion plus 25 ns plus gaps of acquisition less conversion
// - hardware burst needs burst and enable pins both high at reset release
// - in hardware burst the count pins during busy set the next sequence
// - software burst needs the config burst bit and enable bit both set
// - burst readout fits inside one chip-select assertion
// - the 32 stack steps sit at register indices 0x20 to 0x3F
module acs_sequencer #(
   parameter int T_CONV_NS = 400,
   parameter int T_ACQ_NS = 1000
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic convert_start_pin,
   input wire logic partial_reset_n,
   input wire logic hw_mode_pin,
   input wire logic sequencer_enable,
   input wire logic burst_pin,
   input wire logic [2:0] channel_count_pins,
   output logic busy,
   output logic conv_strobe,
   output logic [3:0] adc_a_channel_select,
   output logic [3:0] adc_b_channel_select,
   output logic [4:0] conv_step,
   output logic [5:0] seq_len,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // ==================================================
   // timing counts, least times rounded up
   localparam int CONV_CYC = (T_CONV_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS;
   localparam int FIRST_CYC = (T_CONV_NS + `ACS_FIRST_EXTRA_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS;
   localparam int GAP_CYC = (T_ACQ_NS - T_CONV_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS;

   if (T_CONV_NS < 1 || T_ACQ_NS <= T_CONV_NS || FIRST_CYC > 65535 || GAP_CYC > 65535) begin : g_bad_timing
      $error("acs_sequencer: timing parameters out of range");
   end

   acs_pkg::acs_state_s s_r;
   acs_pkg::acs_state_s s_nxt;

   logic seq_on;
   logic burst_on;
   logic cur_last;
   logic cv_edge;
   logic start;
   logic done;
   logic [8:0] cur_sel;
   logic [8:0] nxt_sel;
   logic [5:0] sw_len;

   // ==================================================
   // helpers
   function automatic logic [8:0] reg_read(input acs_pkg::acs_state_s s, input logic [5:0] idx);
      logic [8:0] v;
      v = 9'h000;
      if (idx == `ACS_IDX_CFG) begin
         v = s.cfg;
      end else if (idx == `ACS_IDX_CHAN) begin
         v = s.chan;
      end else if (idx >= `ACS_IDX_RANGE0 && idx <= `ACS_IDX_RANGE3) begin
         v = s.range[2'(idx - `ACS_IDX_RANGE0)];
      end else if (idx >= `ACS_IDX_STACK0) begin
         v = s.stack[5'(idx - `ACS_IDX_STACK0)];
      end
      return v;
   endfunction

   function automatic logic is_data_reg(input logic [5:0] idx);
      return idx == `ACS_IDX_CFG || idx == `ACS_IDX_CHAN || (idx >= `ACS_IDX_RANGE0 && idx <= `ACS_IDX_RANGE3)
         || idx >= `ACS_IDX_STACK0;
   endfunction

   function automatic logic is_mapped(input logic [5:0] idx);
      return is_data_reg(idx) || idx == `ACS_IDX_FRAME || idx == `ACS_IDX_STATUS;
   endfunction

   // channel pair of a step: {last flag, b select, a select}
   function automatic logic [8:0] step_sel(input acs_pkg::acs_state_s s, input logic [4:0] p, input logic son);
      logic [8:0] v;
      v = 9'h000;
      if (!son) begin
         v = s.hw_mode ? 9'h100 : {1'b1, s.chan[`ACS_SEL_B_MSB:`ACS_SEL_A_LSB]};
      end else if (s.hw_mode) begin
         v = {p[2:0] == s.hw_last, 1'b0, p[2:0], 1'b0, p[2:0]};
      end else begin
         v = s.stack[p];
      end
      return v;
   endfunction

   // ==================================================
   // derived conditions
   always_comb begin
      seq_on = s_r.hw_mode ? s_r.hw_seq : s_r.cfg[`ACS_CFG_SEQ];
      burst_on = seq_on && (s_r.hw_mode ? s_r.hw_burst : s_r.cfg[`ACS_CFG_BURST]);
      cur_sel = step_sel(s_r, s_r.ptr, seq_on);
      nxt_sel = step_sel(s_r, 5'(s_r.ptr + 5'h01), seq_on);
      // a stack with no last flag still ends at the top step, so a burst cannot run forever
      cur_last = cur_sel[`ACS_STK_LAST] || s_r.ptr == 5'(`ACS_STACK_DEPTH - 1);
      cv_edge = s_r.cv_s2 && !s_r.cv_prev;
      start = s_r.st == acs_pkg::ACS_IDLE && s_r.strap_done && s_r.part_s2 && cv_edge;
      done = s_r.st == acs_pkg::ACS_CONV && s_r.tmr == 16'h0000 && s_r.part_s2;
      sw_len = 6'(`ACS_STACK_DEPTH);
      for (int i = `ACS_STACK_DEPTH - 1; i >= 0; i--) begin
         if (s_r.stack[i][`ACS_STK_LAST]) begin
            sw_len = 6'(i + 1);
         end
      end
   end

   // ==================================================
   // next state
   always_comb begin
      logic [5:0] widx;
      logic [5:0] ridx;
      logic [8:0] wval;
      logic [8:0] old;
      logic [15:0] fr;
      logic [5:0] fidx;
      widx = s_axi_awaddr[7:2];
      ridx = s_axi_araddr[7:2];
      old = reg_read(s_r, widx);
      wval = {s_axi_wstrb[1] ? s_axi_wdata[8] : old[8], s_axi_wstrb[0] ? s_axi_wdata[7:0] : old[7:0]};
      fr = s_axi_wdata[15:0];
      fidx = fr[`ACS_FR_ADDR_MSB:`ACS_FR_ADDR_LSB];
      s_nxt = s_r;

      // synchronisers
      s_nxt.cv_s1 = convert_start_pin;
      s_nxt.cv_s2 = s_r.cv_s1;
      s_nxt.cv_prev = s_r.cv_s2;
      s_nxt.part_s1 = partial_reset_n;
      s_nxt.part_s2 = s_r.part_s1;
      s_nxt.mode_s1 = hw_mode_pin;
      s_nxt.mode_s2 = s_r.mode_s1;
      s_nxt.seq_s1 = sequencer_enable;
      s_nxt.seq_s2 = s_r.seq_s1;
      s_nxt.burst_s1 = burst_pin;
      s_nxt.burst_s2 = s_r.burst_s1;
      s_nxt.cnt_s1 = channel_count_pins;
      s_nxt.cnt_s2 = s_r.cnt_s1;

      // straps caught once the synchronisers hold post-release values
      if (!s_r.strap_done) begin
         if (s_r.strap_cnt == `ACS_SYNC_WAIT) begin
            s_nxt.strap_done = 1'b1;
            s_nxt.hw_mode = s_r.mode_s2;
            s_nxt.hw_seq = s_r.seq_s2;
            s_nxt.hw_burst = s_r.seq_s2 && s_r.burst_s2;
            s_nxt.hw_last = s_r.cnt_s2;
         end else begin
            s_nxt.strap_cnt = 2'(s_r.strap_cnt + 2'h1);
         end
      end

      // sequencer
      s_nxt.conv_stb = 1'b0;
      s_nxt.seq_len = seq_on ? (s_r.hw_mode ? 6'({3'h0, s_r.hw_last} + 6'h01) : sw_len) : 6'h01;
      case (s_r.st)
         acs_pkg::ACS_IDLE: begin
            if (start) begin
               s_nxt.st = acs_pkg::ACS_CONV;
               s_nxt.busy = 1'b1;
               s_nxt.tmr = burst_on ? 16'(FIRST_CYC - 1) : 16'(CONV_CYC - 1);
               s_nxt.a_sel = cur_sel[`ACS_SEL_A_MSB:`ACS_SEL_A_LSB];
               s_nxt.b_sel = cur_sel[`ACS_SEL_B_MSB:`ACS_SEL_B_LSB];
               s_nxt.step = s_r.ptr;
            end
         end
         acs_pkg::ACS_CONV: begin
            if (done) begin
               s_nxt.conv_stb = 1'b1;
               if (cur_last) begin
                  s_nxt.ptr = 5'h00;
                  if (s_r.hw_mode) begin
                     s_nxt.hw_last = s_r.cnt_s2;
                  end
               end else begin
                  s_nxt.ptr = 5'(s_r.ptr + 5'h01);
               end
               if (burst_on && !cur_last) begin
                  s_nxt.tmr = 16'(GAP_CYC - 1);
                  s_nxt.a_sel = nxt_sel[`ACS_SEL_A_MSB:`ACS_SEL_A_LSB];
                  s_nxt.b_sel = nxt_sel[`ACS_SEL_B_MSB:`ACS_SEL_B_LSB];
                  s_nxt.step = 5'(s_r.ptr + 5'h01);
               end else begin
                  s_nxt.st = acs_pkg::ACS_IDLE;
                  s_nxt.busy = 1'b0;
               end
            end else begin
               s_nxt.tmr = 16'(s_r.tmr - 16'h0001);
            end
         end
         default: begin
            s_nxt.st = acs_pkg::ACS_IDLE;
            s_nxt.busy = 1'b0;
         end
      endcase

      // partial reset keeps every register, only the sequence restarts
      if (!s_r.part_s2) begin
         s_nxt.ptr = 5'h00;
         s_nxt.st = acs_pkg::ACS_IDLE;
         s_nxt.busy = 1'b0;
         s_nxt.tmr = 16'h0000;
      end

      // axi write: address and data taken together
      s_nxt.awready = 1'b0;
      s_nxt.wready = 1'b0;
      if (s_axi_awvalid && s_axi_wvalid && !s_r.awready && !s_r.bvalid) begin
         s_nxt.awready = 1'b1;
         s_nxt.wready = 1'b1;
      end
      if (s_r.awready) begin
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = is_mapped(widx) ? `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
         if (widx == `ACS_IDX_FRAME) begin
            if (fr[`ACS_FR_WRITE]) begin
               old = reg_read(s_r, fidx);
               wval = fr[`ACS_FR_DATA_MSB:`ACS_FR_DATA_LSB];
               widx = fidx;
            end else begin
               s_nxt.frame_rd = {1'b0, fidx, reg_read(s_r, fidx)};
               widx = `ACS_IDX_STATUS;
            end
         end
         if (widx == `ACS_IDX_CFG) begin
            s_nxt.cfg = wval;
         end else if (widx == `ACS_IDX_CHAN) begin
            s_nxt.chan = wval;
         end else if (widx >= `ACS_IDX_RANGE0 && widx <= `ACS_IDX_RANGE3) begin
            s_nxt.range[2'(widx - `ACS_IDX_RANGE0)] = wval;
         end else if (widx >= `ACS_IDX_STACK0) begin
            s_nxt.stack[5'(widx - `ACS_IDX_STACK0)] = wval;
         end
      end else if (s_r.bvalid && s_axi_bready) begin
         s_nxt.bvalid = 1'b0;
      end

      // axi read
      s_nxt.arready = 1'b0;
      if (s_axi_arvalid && !s_r.arready && !s_r.rvalid) begin
         s_nxt.arready = 1'b1;
      end
      if (s_r.arready) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = is_mapped(ridx) ? `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
         if (ridx == `ACS_IDX_STATUS) begin
            s_nxt.rdata = {19'h00000, s_r.strap_done, s_r.hw_burst, s_r.hw_seq, s_r.hw_mode, s_r.hw_last,
               s_r.ptr, s_r.busy};
         end else if (ridx == `ACS_IDX_FRAME) begin
            s_nxt.rdata = {16'h0000, s_r.frame_rd};
         end else begin
            s_nxt.rdata = {23'h000000, reg_read(s_r, ridx)};
         end
      end else if (s_r.rvalid && s_axi_rready) begin
         s_nxt.rvalid = 1'b0;
      end

      // full reset: only constants
      if (!aresetn) begin
         s_nxt = '0;
         s_nxt.st = acs_pkg::ACS_IDLE;
         s_nxt.cfg = `ACS_CFG_RST;
         s_nxt.chan = `ACS_CHAN_RST;
         for (int i = 0; i < 4; i++) begin
            s_nxt.range[i] = `ACS_RANGE_RST;
         end
         for (int i = 0; i < `ACS_STACK_DEPTH; i++) begin
            s_nxt.stack[i] = (i < `ACS_HW_PAIRS) ? {1'b0, 4'(i), 4'(i)} : `ACS_STACK_RST;
         end
      end
   end

   always_ff @(posedge aclk) begin
      s_r <= s_nxt;
   end

   // ==================================================
   // outputs
   assign busy = s_r.busy;
   assign conv_strobe = s_r.conv_stb;
   assign adc_a_channel_select = s_r.a_sel;
   assign adc_b_channel_select = s_r.b_sel;
   assign conv_step = s_r.step;
   assign seq_len = s_r.seq_len;
   assign s_axi_awready = s_r.awready;
   assign s_axi_wready = s_r.wready;
   assign s_axi_bvalid = s_r.bvalid;
   assign s_axi_bresp = s_r.bresp;
   assign s_axi_arready = s_r.arready;
   assign s_axi_rvalid = s_r.rvalid;
   assign s_axi_rdata = s_r.rdata;
   assign s_axi_rresp = s_r.rresp;

   // ==================================================
   // assertions
   localparam int FIRST_M1 = FIRST_CYC - 1;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_start_raises_busy: assert property (start |=> busy && s_r.st == acs_pkg::ACS_CONV)
      else $error("busy did not rise after a start edge");
   a_busy_holds: assert property (busy && !done && s_r.part_s2 |=> busy)
      else $error("busy fell before the sequence finished");
   a_wrap_to_zero: assert property (done && cur_last |=> s_r.ptr == 5'h00)
      else $error("pointer did not wrap after the last step");
   a_step_advance: assert property (done && !cur_last |=> s_r.ptr == 5'($past(s_r.ptr) + 5'h01))
      else $error("pointer did not advance by one step");
   a_burst_continues: assert property (done && burst_on && !cur_last |=> busy && conv_strobe
      && s_r.st == acs_pkg::ACS_CONV)
      else $error("burst stopped before the last step");
   a_single_step: assert property (done && !burst_on |=> !busy ##1 !busy)
      else $error("non-burst start converted more than one step");
   a_partial_keeps: assert property (!s_r.part_s2 |=> s_r.ptr == 5'h00 && s_r.cfg == $past(s_r.cfg))
      else $error("partial reset changed registers or left the pointer");
   a_sel_follows: assert property (start |=> adc_a_channel_select == $past(cur_sel[3:0])
      && adc_b_channel_select == $past(cur_sel[7:4]))
      else $error("selects do not match the step");
   a_hw_from_zero: assert property (start && s_r.hw_mode && seq_on && s_r.ptr == 5'h00
      |=> adc_a_channel_select == 4'h0 && adc_b_channel_select == 4'h0)
      else $error("hardware sequence did not start at pair zero");
   a_burst_first: assert property (start && burst_on |=> s_r.tmr == 16'(FIRST_M1))
      else $error("first burst conversion time wrong");
   a_write_resp: assert property (s_axi_awready |=> s_axi_bvalid)
      else $error("write response missing");

   c_burst_run: cover property (start && burst_on ##[1:1000] done && cur_last);
   c_wrap: cover property (done && cur_last && !burst_on);
   c_partial: cover property (busy && !s_r.part_s2);
   c_frame_write: cover property (s_axi_awready && s_axi_awaddr[7:2] == `ACS_IDX_FRAME);

endmodule

/* acs_host_model.sv */
// host controller model that issues convert-start pulses and waits out busy
`timescale 1ns/1ps
// ==================================================
// convert-start driver
module acs_host_model (
   input wire logic aclk,
   input wire logic req,
   input wire logic [3:0] hold,
   input wire logic busy,
   output logic convert_start_pin,
   output logic done
);
   int n;
   initial begin
      convert_start_pin = 1'b0;
      done = 1'b0;
      forever begin
         @(posedge aclk);
         done <= 1'b0;
         if (req === 1'b1) begin
            // a long hold mimics a slow host; only the rising edge counts
            convert_start_pin <= 1'b1;
            repeat (hold) @(posedge aclk);
            convert_start_pin <= 1'b0;
            n = 0;
            while (busy !== 1'b1 && n < 20) begin
               @(posedge aclk);
               n++;
            end
            // results are only fetched once busy is low again
            while (busy === 1'b1 && n < 3000) begin
               @(posedge aclk);
               n++;
            end
            done <= 1'b1;
         end
      end
   end
endmodule

/* test_adc_channel_sequencer_burst.sv */
// self-checking bench of the channel sequencer
`timescale 1ns/1ps
`include "acs_defines.svh"
module test_adc_channel_sequencer_burst;
   logic aclk, aresetn, partial_reset_n, hw_mode_pin, sequencer_enable, burst_pin;
   logic busy, conv_strobe, convert_start_pin, req, done;
   logic [2:0] channel_count_pins;
   logic [3:0] a_sel, b_sel, hold, wstrb;
   logic [4:0] conv_step;
   logic [5:0] seq_len;
   logic [7:0] awaddr, araddr;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata, v;
   logic [1:0] bresp, rresp;
   logic [8:0] stk[32];
   logic [12:0] got[$], exp_q[$];
   logic [12:0] prev_sel;
   int failures, n_checks, ptr, d, hw_last;

   acs_sequencer #(.T_CONV_NS(20), .T_ACQ_NS(50)) u_dut (
      .aclk(aclk), .aresetn(aresetn), .convert_start_pin(convert_start_pin),
      .partial_reset_n(partial_reset_n), .hw_mode_pin(hw_mode_pin),
      .sequencer_enable(sequencer_enable), .burst_pin(burst_pin),
      .channel_count_pins(channel_count_pins), .busy(busy), .conv_strobe(conv_strobe),
      .adc_a_channel_select(a_sel), .adc_b_channel_select(b_sel), .conv_step(conv_step),
      .seq_len(seq_len), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   acs_host_model u_host (.aclk(aclk), .req(req), .hold(hold), .busy(busy),
      .convert_start_pin(convert_start_pin), .done(done));

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   // selects move on to the next step at the strobe edge, so keep the ones just finished
   always @(posedge aclk) begin
      if (conv_strobe === 1'b1) got.push_back(prev_sel);
      prev_sel <= {conv_step, b_sel, a_sel};
   end

   // ==================================================
   // compare and bus tasks
   task chk_reg(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task chk_conv(input logic [12:0] g, input logic [12:0] e);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task axw(input logic [5:0] idx, input logic [31:0] dat, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr <= {idx, 2'b00};
      wdata <= dat;
      {awvalid, wvalid, bready} <= 3'h7;
      do begin
         @(posedge aclk);
         n++;
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (bready && bvalid === 1'b1) begin
            bready <= 1'b0;
            chk_reg({30'h0, bresp}, {30'h0, er});
         end
      end while ((awvalid || wvalid || bready) && n < 100);
      if (n >= 100) failures++;
   endtask

   task axr(input logic [5:0] idx, input logic [31:0] ed, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= {idx, 2'b00};
      {arvalid, rready} <= 2'h3;
      do begin
         @(posedge aclk);
         n++;
         if (arready === 1'b1) arvalid <= 1'b0;
         if (rready && rvalid === 1'b1) begin
            rready <= 1'b0;
            chk_reg(rdata, ed);
            chk_reg({30'h0, rresp}, {30'h0, er});
         end
      end while ((arvalid || rready) && n < 100);
      if (n >= 100) failures++;
   endtask

   // ==================================================
   // conversion runs against the model queue
   task go(input logic [12:0] m);
      int n;
      n = 0;
      @(posedge aclk);
      req <= 1'b1;
      hold <= 4'($urandom_range(9, 1));
      @(posedge aclk);
      req <= 1'b0;
      while (done !== 1'b1 && n < 5000) begin
         @(posedge aclk);
         n++;
      end
      if (n >= 5000) failures++;
      chk_reg(got.size(), exp_q.size());
      while (got.size() > 0 && exp_q.size() > 0) chk_conv(got.pop_front() & m, exp_q.pop_front() & m);
      got.delete();
      exp_q.delete();
   endtask

   task model_sw(input bit burst);
      bit last;
      do begin
         exp_q.push_back({5'(ptr), stk[ptr][7:4], stk[ptr][3:0]});
         last = stk[ptr][8];
         ptr = last ? 0 : ptr + 1;
      end while (burst && !last);
   endtask

   task hw_run;
      for (int p = 0; p <= hw_last; p++) exp_q.push_back({5'(p), 4'(p), 4'(p)});
      go(13'h1FFF);
      // pins held through the run decide the next length
      hw_last = int'(channel_count_pins);
   endtask

   task do_reset;
      aresetn <= 1'b0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (6) @(posedge aclk);
      ptr = 0;
   endtask

   task final_report;
      $display("checks=%0d failures=%0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      #200000;
      failures++;
      final_report;
   end

   // ==================================================
   // main sequence
   initial begin
      {aresetn, partial_reset_n, req, hold, wstrb} = {3'h2, 4'h1, 4'hF};
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wdata} = 48'h0;
      {failures, n_checks} = 0;
      v = $urandom(32'hE4045738);
      {hw_mode_pin, sequencer_enable, burst_pin, channel_count_pins} = {3'h7, 3'h2};
      do_reset;
      channel_count_pins <= 3'h1;
      hw_last = 2;
      hw_run;
      hw_run;
      {hw_mode_pin, sequencer_enable, burst_pin} <= 3'h0;
      do_reset;
      axr(6'h25, 32'h55, `ACS_RESP_OKAY);
      axr(6'h08, 32'h0, `ACS_RESP_SLVERR);
      d = $urandom_range(6, 2);
      stk[0] = 9'h0A3;
      axw(`ACS_IDX_FRAME, {16'h0, 1'b1, `ACS_IDX_STACK0, 9'h0A3}, `ACS_RESP_OKAY);
      axr(`ACS_IDX_STACK0, 32'h0A3, `ACS_RESP_OKAY);
      for (int i = 1; i < 32; i++) begin
         stk[i] = {i == d - 1, 8'($urandom)};
         axw(6'(32 + i), {23'h0, stk[i]}, `ACS_RESP_OKAY);
      end
      axw(`ACS_IDX_CFG, 32'h20, `ACS_RESP_OKAY);
      chk_reg({26'h0, seq_len}, 32'(d));
      repeat (d + 1) begin
         model_sw(1'b0);
         go(13'h1FFF);
      end
      // pointer sits at step one here, so a return to zero is visible
      partial_reset_n <= 1'b0;
      repeat (4) @(posedge aclk);
      partial_reset_n <= 1'b1;
      repeat (4) @(posedge aclk);
      ptr = 0;
      repeat (d) begin
         model_sw(1'b0);
         go(13'h1FFF);
      end
      axw(`ACS_IDX_CFG, 32'h60, `ACS_RESP_OKAY);
      model_sw(1'b1);
      go(13'h1FFF);
      stk[d - 1][8] = 1'b0;
      stk[31][8] = 1'b1;
      axw(6'(32 + d - 1), {23'h0, stk[d - 1]}, `ACS_RESP_OKAY);
      axw(`ACS_IDX_STACK31, {23'h0, stk[31]}, `ACS_RESP_OKAY);
      model_sw(1'b1);
      go(13'h1FFF);
      // sequencer off: burst bit alone must give a single conversion of the channel register
      v = {24'h0, 8'($urandom)};
      axw(`ACS_IDX_CHAN, v, `ACS_RESP_OKAY);
      axw(`ACS_IDX_CFG, 32'h40, `ACS_RESP_OKAY);
      exp_q.push_back({5'h00, v[7:0]});
      go(13'h00FF);
      final_report;
   end
endmodule
